// File: design/sco_defs.svh
`ifndef SCO_DEFS_SVH
`define SCO_DEFS_SVH

// serial framing
`define SCO_ADDR_BYTE 8'hD2
`define SCO_BITS_PER_BYTE 4'h8
`define SCO_POS_ADDR 4'h0
`define SCO_POS_FIRST_REG 4'h6
`define SCO_POS_LAST_REG 4'h9
`define SCO_POS_END 4'hA
// register defaults and writable bits
`define SCO_FF_DEFAULT 8'h00
`define SCO_CU_DEFAULT 8'h45
`define SCO_PCI_DEFAULT 8'hEF
`define SCO_REF_DEFAULT 8'h23
`define SCO_FF_MASK 8'h7B
`define SCO_CU_MASK 8'h45
`define SCO_PCI_MASK 8'hEF
`define SCO_REF_MASK 8'h23
// field positions
`define SCO_SRC_BIT 3
`define SCO_CODE_HI 6
`define SCO_CODE_LO 4
`define SCO_FUNC_HI 1
`define SCO_FUNC_LO 0
`define SCO_EN_DUAL 6
`define SCO_EN_CPU_B 2
`define SCO_EN_CPU_A 0
`define SCO_EN_PCI_FREE 7
`define SCO_EN_INTERRUPT_CTRL_REF_CLOCK 5
`define SCO_EN_HIGH_DRIVE_REF_CLOCK 0
// function codes
`define SCO_FUNC_NORMAL 2'h0
`define SCO_FUNC_TEST 2'h1
`define SCO_FUNC_SPREAD 2'h2
`define SCO_FUNC_TRI 2'h3
// frequencies in units of 10 kHz
`define SCO_CPU_PIN1 16'h2710
`define SCO_PCI_PIN1 16'h0D02
`define SCO_CPU_PIN0 16'h1A18
`define SCO_PCI_PIN0 16'h0D0C
`define SCO_CPU_C0 16'h1AC2
`define SCO_PCI_C0 16'h0D61
`define SCO_CPU_C1 16'h1D4C
`define SCO_PCI_C1 16'h0EA6
`define SCO_CPU_C2 16'h208A
`define SCO_PCI_C2 16'h1040
`define SCO_CPU_C3 16'h1A18
`define SCO_PCI_C3 16'h0D0C
`define SCO_CPU_C4 16'h283C
`define SCO_PCI_C4 16'h0D61
`define SCO_CPU_C5 16'h2BC0
`define SCO_PCI_C5 16'h0E92
`define SCO_CPU_C6 16'h3412
`define SCO_PCI_C6 16'h115B
`define SCO_CPU_C7 16'h2710
`define SCO_PCI_C7 16'h0D02
// frequency ramp timing
`define SCO_CLK_PERIOD_NS 50
`define SCO_RAMP_STEP_NS 50000
`define SCO_RAMP_CYCLES (`SCO_RAMP_STEP_NS / `SCO_CLK_PERIOD_NS)
`define SCO_RAMP_INC 16'h000A
`endif

// File: design/sco_pkg.sv
package sco_pkg;
   // the four control registers as one carrier
   typedef struct packed {
      logic [7:0] ref_en;    // reference output enables
      logic [7:0] pci_en;    // pci output enables
      logic [7:0] cpu_usb_en; // cpu and 24/48 enables
      logic [7:0] freq_func; // frequency and function control
   } sco_cfg_t;
   // one bit per clock output
   typedef struct packed {
      logic cpu_a;
      logic cpu_b;
      logic pci_free;
      logic [5:0] pci;       // pci clocks 6 down to 1
      logic interrupt_ctrl_ref_clock;
      logic high_drive_ref_clock;
      logic usb48;
      logic dual;
   } sco_clk_t;
   // serial receiver states
   typedef enum logic [1:0] {SCO_IDLE, SCO_BITS, SCO_ACK, SCO_SKIP} sco_state_t;
endpackage : sco_pkg

// File: design/sco_sync.sv
`timescale 1ns/10ps
// two flop synchroniser, one chain per bit
module sco_sync #(
   parameter int WIDTH = 3
) (
   input wire logic ref_clk, // sampling clock
   input wire logic nrst, // async reset, active low
   input wire logic [WIDTH-1:0] async_in, // raw pin levels
   input wire logic [WIDTH-1:0] rst_val, // unused, reset always loads idle high; kept so the port list is stable
   output logic [WIDTH-1:0] sync_out // synchronised levels
);
   genvar g;
   for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q; // first stage, read only by second stage
      logic sync_q; // second stage
      // reset to idle high, the serial lines idle high through pull-ups
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
         end else begin
            meta_q <= async_in[g];
            sync_q <= meta_q;
         end
      end
      assign sync_out[g] = sync_q;
   end
   logic unused_rst_val; // kept so the port list is stable
   assign unused_rst_val = ^rst_val;
endmodule : sco_sync

// File: design/sco_top.sv
`timescale 1ns/10ps
`include "sco_defs.svh"
// serial configured clock output control
module sco_top #(
   parameter int RAMP_CYCLES = `SCO_RAMP_CYCLES
) (
   input wire logic ref_clk, // 20 MHz system clock
   input wire logic nrst, // async reset, active low
   input wire logic serial_clock_line, // serial clock pin
   input wire logic serial_data_line_i, // serial data pin level
   output logic serial_data_line_o, // serial data drive value
   output logic serial_data_line_oe_n, // low while pulling data low
   input wire logic cpu_rate_select_pin, // 1 selects 100 MHz, 0 selects 66.8 MHz
   input wire sco_pkg::sco_clk_t clk_raw, // ungated clocks from the synthesiser
   output sco_pkg::sco_clk_t clk_out, // gated clock outputs
   output logic clk_oe_n, // low while clock outputs drive
   output logic pll_bypass, // test function, crystal dividers feed outputs
   output logic spread_en, // cpu and pci modulation on
   output logic [15:0] cpu_freq, // cpu target now, 10 kHz units
   output logic [15:0] pci_freq, // pci target now, 10 kHz units
   output sco_pkg::sco_cfg_t cfg // current control registers
);
   logic scl_s, sda_s, pin_s; // synchronised pins
   logic scl_q, sda_q; // previous samples for edge finding
   sco_pkg::sco_state_t state_q; // receiver state
   logic [3:0] bit_cnt_q; // bits of current byte
   logic [3:0] pos_q; // byte position, address is zero
   logic [7:0] shift_q; // incoming byte
   logic ack_q; // drive acknowledge
   sco_pkg::sco_cfg_t cfg_q; // control registers
   logic [15:0] ramp_cnt_q; // ramp interval counter
   logic [15:0] cur_q [2]; // ramped frequencies, cpu then pci
   logic [15:0] tgt [2]; // target frequencies

   sco_sync #(.WIDTH(3)) u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in({serial_clock_line, serial_data_line_i, cpu_rate_select_pin}),
      .rst_val(3'h7),
      .sync_out({scl_s, sda_s, pin_s})
   );

   // edge and framing decode
   wire scl_rise = scl_s && !scl_q;
   wire scl_fall = !scl_s && scl_q;
   wire start_c = scl_s && scl_q && sda_q && !sda_s;
   wire stop_c = scl_s && scl_q && !sda_q && sda_s;
   wire byte_done = (bit_cnt_q == `SCO_BITS_PER_BYTE);
   wire addr_bad = (pos_q == `SCO_POS_ADDR) && (shift_q != `SCO_ADDR_BYTE);
   wire past_end = (pos_q >= `SCO_POS_END);
   wire commit = (state_q == sco_pkg::SCO_ACK) && scl_rise;
   wire in_regs = (pos_q >= `SCO_POS_FIRST_REG) && (pos_q <= `SCO_POS_LAST_REG);
   wire [1:0] reg_sel = 2'(pos_q - `SCO_POS_FIRST_REG);

   // edge history
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // receiver: start and stop win over everything, bytes shift msb first
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= sco_pkg::SCO_IDLE;
         bit_cnt_q <= 4'h0;
         pos_q <= 4'h0;
         shift_q <= 8'h00;
         ack_q <= 1'b0;
      end else if (start_c) begin
         state_q <= sco_pkg::SCO_BITS;
         bit_cnt_q <= 4'h0;
         pos_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (stop_c) begin
         state_q <= sco_pkg::SCO_IDLE;
         ack_q <= 1'b0;
      end else begin
         case (state_q)
            sco_pkg::SCO_BITS: begin
               if (scl_rise && !byte_done) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall && byte_done) begin
                  // a foreign address or an eleventh byte gets no acknowledge
                  if (addr_bad || past_end) begin
                     state_q <= sco_pkg::SCO_SKIP;
                  end else begin
                     state_q <= sco_pkg::SCO_ACK;
                     ack_q <= 1'b1;
                  end
               end
            end
            sco_pkg::SCO_ACK: begin
               if (commit) begin
                  pos_q <= pos_q + 4'h1;
               end else if (scl_fall) begin
                  ack_q <= 1'b0;
                  bit_cnt_q <= 4'h0;
                  state_q <= sco_pkg::SCO_BITS;
               end
            end
            sco_pkg::SCO_SKIP: begin
               ack_q <= 1'b0;
            end
            default: begin
               ack_q <= 1'b0;
            end
         endcase
      end
   end

   // only the acknowledge is ever driven, nothing is read back
   assign serial_data_line_o = 1'b0;
   assign serial_data_line_oe_n = !ack_q;

   // register write on the acknowledge clock of a complete byte
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q.freq_func <= `SCO_FF_DEFAULT;
         cfg_q.cpu_usb_en <= `SCO_CU_DEFAULT;
         cfg_q.pci_en <= `SCO_PCI_DEFAULT;
         cfg_q.ref_en <= `SCO_REF_DEFAULT;
      end else if (commit && in_regs) begin
         // reserved bits are stored as zero whatever the host sends
         case (reg_sel)
            2'h0: cfg_q.freq_func <= shift_q & `SCO_FF_MASK;
            2'h1: cfg_q.cpu_usb_en <= shift_q & `SCO_CU_MASK;
            2'h2: cfg_q.pci_en <= shift_q & `SCO_PCI_MASK;
            default: cfg_q.ref_en <= shift_q & `SCO_REF_MASK;
         endcase
      end
   end
   assign cfg = cfg_q;

   // frequency code decode, cpu in upper half, pci in lower
   function automatic logic [31:0] sco_code_freq(input logic [2:0] code);
      logic [31:0] f;
      f = {`SCO_CPU_C7, `SCO_PCI_C7};
      case (code)
         3'h0: f = {`SCO_CPU_C0, `SCO_PCI_C0};
         3'h1: f = {`SCO_CPU_C1, `SCO_PCI_C1};
         3'h2: f = {`SCO_CPU_C2, `SCO_PCI_C2};
         3'h3: f = {`SCO_CPU_C3, `SCO_PCI_C3};
         3'h4: f = {`SCO_CPU_C4, `SCO_PCI_C4};
         3'h5: f = {`SCO_CPU_C5, `SCO_PCI_C5};
         3'h6: f = {`SCO_CPU_C6, `SCO_PCI_C6};
         default: f = {`SCO_CPU_C7, `SCO_PCI_C7};
      endcase
      return f;
   endfunction : sco_code_freq

   wire use_code = cfg_q.freq_func[`SCO_SRC_BIT];
   wire [2:0] code = cfg_q.freq_func[`SCO_CODE_HI:`SCO_CODE_LO];
   wire [31:0] code_f = sco_code_freq(code);
   wire [31:0] pin_f = pin_s ? {`SCO_CPU_PIN1, `SCO_PCI_PIN1} : {`SCO_CPU_PIN0, `SCO_PCI_PIN0};
   wire [31:0] sel_f = use_code ? code_f : pin_f;
   assign tgt[0] = sel_f[31:16];
   assign tgt[1] = sel_f[15:0];
   wire ramp_tick = (ramp_cnt_q == 16'(RAMP_CYCLES - 1));

   // ramp interval timer
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ramp_cnt_q <= 16'h0000;
      end else begin
         ramp_cnt_q <= ramp_tick ? 16'h0000 : ramp_cnt_q + 16'h0001;
      end
   end

   // each synthesiser target walks toward its goal, so the cpu never sees a jump
   genvar g;
   for (g = 0; g < 2; g++) begin : g_ramp
      wire up = tgt[g] > cur_q[g];
      wire near = up ? (tgt[g] - cur_q[g] <= `SCO_RAMP_INC) : (cur_q[g] - tgt[g] <= `SCO_RAMP_INC);
      wire [15:0] step_d = near ? tgt[g] : (up ? cur_q[g] + `SCO_RAMP_INC : cur_q[g] - `SCO_RAMP_INC);
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            cur_q[g] <= (g == 0) ? `SCO_CPU_PIN0 : `SCO_PCI_PIN0;
         end else if (ramp_tick) begin
            cur_q[g] <= step_d;
         end
      end
      // distance moved since the previous clock, worked out inside the property where sampling is legal
      a_ramp_bounded: assert property (@(posedge ref_clk) disable iff (!nrst)
         ((cur_q[g] >= $past(cur_q[g])) ? cur_q[g] - $past(cur_q[g]) : $past(cur_q[g]) - cur_q[g]) <= `SCO_RAMP_INC)
         else $error("frequency moved more than one step");
   end
   assign cpu_freq = cur_q[0];
   assign pci_freq = cur_q[1];

   // function decode
   wire [1:0] func = cfg_q.freq_func[`SCO_FUNC_HI:`SCO_FUNC_LO];
   assign spread_en = (func == `SCO_FUNC_SPREAD);
   assign pll_bypass = (func == `SCO_FUNC_TEST);
   assign clk_oe_n = (func == `SCO_FUNC_TRI);

   // output gating: a disabled output is held low; raw clocks must change only while low
   // to keep gated edges clean, which the synthesiser guarantees for its own outputs
   assign clk_out.cpu_a = clk_raw.cpu_a & cfg_q.cpu_usb_en[`SCO_EN_CPU_A];
   assign clk_out.cpu_b = clk_raw.cpu_b & cfg_q.cpu_usb_en[`SCO_EN_CPU_B];
   assign clk_out.dual = clk_raw.dual & cfg_q.cpu_usb_en[`SCO_EN_DUAL];
   assign clk_out.pci_free = clk_raw.pci_free & cfg_q.pci_en[`SCO_EN_PCI_FREE];
   assign clk_out.pci = clk_raw.pci & {cfg_q.pci_en[6:5], cfg_q.pci_en[3:0]};
   assign clk_out.interrupt_ctrl_ref_clock = clk_raw.interrupt_ctrl_ref_clock & cfg_q.ref_en[`SCO_EN_INTERRUPT_CTRL_REF_CLOCK];
   assign clk_out.high_drive_ref_clock = clk_raw.high_drive_ref_clock & cfg_q.ref_en[`SCO_EN_HIGH_DRIVE_REF_CLOCK];
   assign clk_out.usb48 = clk_raw.usb48;

   // checks
   sequence s_ack_clock;
      (state_q == sco_pkg::SCO_ACK) && scl_rise;
   endsequence
   a_commit_needs_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
      $changed(cfg_q) |-> $past(commit) && $past(pos_q) != `SCO_POS_ADDR) else $error("register changed without address");
   a_commit_window: assert property (@(posedge ref_clk) disable iff (!nrst)
      $changed(cfg_q) |-> $past(pos_q) >= `SCO_POS_FIRST_REG && $past(pos_q) <= `SCO_POS_LAST_REG)
      else $error("register written outside data bytes 3 to 6");
   a_ack_drives_low: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_ack_clock |-> !serial_data_line_oe_n ##1 pos_q == $past(pos_q) + 4'h1) else $error("acknowledge step wrong");
   a_bad_addr_skip: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_q == sco_pkg::SCO_BITS) && scl_fall && byte_done && addr_bad && !start_c && !stop_c
      |=> state_q == sco_pkg::SCO_SKIP ##0 serial_data_line_oe_n) else $error("foreign address acknowledged");
   a_pin_source: assert property (@(posedge ref_clk) disable iff (!nrst)
      !use_code |-> tgt[0] == (pin_s ? `SCO_CPU_PIN1 : `SCO_CPU_PIN0)) else $error("pin source ignored");
   a_tristate_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
      clk_oe_n == (func == `SCO_FUNC_TRI) && spread_en == (func == `SCO_FUNC_SPREAD)) else $error("function decode wrong");
   a_cpu_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
      !cfg_q.cpu_usb_en[`SCO_EN_CPU_A] |-> !clk_out.cpu_a) else $error("disabled cpu clock not low");
   a_pci_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
      !cfg_q.pci_en[`SCO_EN_PCI_FREE] |-> !clk_out.pci_free) else $error("disabled pci clock not low");
   a_interrupt_ctrl_ref_clock_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
      !cfg_q.ref_en[`SCO_EN_INTERRUPT_CTRL_REF_CLOCK] |-> !clk_out.interrupt_ctrl_ref_clock) else $error("disabled interrupt clock not low");
   a_no_readback: assert property (@(posedge ref_clk) disable iff (!nrst)
      !serial_data_line_oe_n |-> state_q == sco_pkg::SCO_ACK) else $error("data line driven outside acknowledge");
endmodule : sco_top

// File: dv/sco_host.sv
`timescale 1ns/10ps
// behavioural host on the two-wire link; its clock idles high between frames
module sco_host (
   output logic scl, // serial clock, idle high
   output logic sda_low, // high while the host pulls data low
   input wire logic sda // resolved data line, pulled up
);
   int acks; // acknowledges seen since the last start
   // released bus at time zero
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      acks = 0;
   end
   // start: data falls while the clock is high
   task automatic start();
      sda_low = 1'b1;
      #200 scl = 1'b0;
      acks = 0;
   endtask : start
   // n bits msb first, data moves only mid-low so it never fakes a start or stop
   task automatic bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         #100 sda_low = ~b[i];
         #100 scl = 1'b1;
         #200 scl = 1'b0;
      end
   endtask : bits
   // whole byte, then a ninth clock with data released for the acknowledge
   task automatic put(input logic [7:0] b);
      bits(b, 8);
      #100 sda_low = 1'b0;
      #100 scl = 1'b1;
      #100 acks += (sda === 1'b0);
      #100 scl = 1'b0;
   endtask : put
   // stop: data rises while the clock is high
   task automatic stop();
      #100 sda_low = 1'b1;
      #100 scl = 1'b1;
      #100 sda_low = 1'b0;
      #200;
   endtask : stop
endmodule : sco_host

// File: dv/sco_top_bench.sv
`timescale 1ns/10ps
// self-checking bench: random frames plus wrong address, short and torn writes
module sco_top_bench;
   logic ref_clk = 1'b0; // 20 MHz
   logic nrst = 1'b0; // async reset, active low
   logic pin = 1'b1; // rate select pin
   logic scl; // link clock from the host
   logic sda_low; // host pulls data low
   logic sdo; // device drive value
   logic sdo_oe_n; // device pulls data low when low
   logic oe_n, byp, spr; // function outputs
   logic [15:0] cf, pf, pcf, ppf; // frequencies and last values
   logic [31:0] d, e, t; // frame data and scratch
   logic [31:0] seed = 32'h8D84; // xorshift state
   sco_pkg::sco_clk_t raw = '0; // ungated clocks
   sco_pkg::sco_clk_t cout; // gated clocks
   sco_pkg::sco_cfg_t cfg; // control registers
   int num_errors = 0;
   int n_tests = 0;
   // expected targets per register code, 10 kHz units
   logic [15:0] cpu_t [8] = '{16'd6850, 16'd7500, 16'd8330, 16'd6680, 16'd10300, 16'd11200, 16'd13330, 16'd10000};
   logic [15:0] pci_t [8] = '{16'd3425, 16'd3750, 16'd4160, 16'd3340, 16'd3425, 16'd3730, 16'd4443, 16'd3330};
   // open drain with pull-up: low if either party pulls
   wire logic sda = ~sda_low & (sdo_oe_n | sdo);
   // more than one ramp step between two samples of either frequency
   wire logic jump = (cf - pcf > 16'd10 && pcf - cf > 16'd10) || (pf - ppf > 16'd10 && ppf - pf > 16'd10);

   sco_top #(.RAMP_CYCLES(4)) dut (.ref_clk(ref_clk), .nrst(nrst), .serial_clock_line(scl),
      .serial_data_line_i(sda), .serial_data_line_o(sdo), .serial_data_line_oe_n(sdo_oe_n),
      .cpu_rate_select_pin(pin), .clk_raw(raw), .clk_out(cout), .clk_oe_n(oe_n), .pll_bypass(byp),
      .spread_en(spr), .cpu_freq(cf), .pci_freq(pf), .cfg(cfg));
   sco_host host (.scl(scl), .sda_low(sda_low), .sda(sda));

   // clock
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // gating expected from the enable bits; the usb output is never gated
   function automatic sco_pkg::sco_clk_t exp_clk(input sco_pkg::sco_cfg_t c, input sco_pkg::sco_clk_t r);
      exp_clk = r;
      exp_clk.cpu_a = r.cpu_a & c.cpu_usb_en[0];
      exp_clk.cpu_b = r.cpu_b & c.cpu_usb_en[2];
      exp_clk.dual = r.dual & c.cpu_usb_en[6];
      exp_clk.pci_free = r.pci_free & c.pci_en[7];
      exp_clk.pci = r.pci & {c.pci_en[6:5], c.pci_en[3:0]};
      exp_clk.interrupt_ctrl_ref_clock = r.interrupt_ctrl_ref_clock & c.ref_en[5];
      exp_clk.high_drive_ref_clock = r.high_drive_ref_clock & c.ref_en[0];
   endfunction : exp_clk

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic results();
      if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results

   // address, n bytes after it (data3..6 from v), then an optional torn byte
   task automatic frame(input logic [7:0] a, input logic [31:0] v, input int n, input int part);
      host.start();
      host.put(a);
      for (int i = 1; i <= n; i++) begin
         t = rnd();
         host.put(i < 6 ? t[7:0] : v[8*(i-6)+:8]);
      end
      if (part > 0) host.bits(8'hFF, part);
      host.stop();
   endtask : frame

   // bounded wait for both frequencies to reach their targets
   task automatic settle(input logic [15:0] c, input logic [15:0] p);
      int k;
      // looked at mid-cycle, well away from the edge that updates the ramp
      for (k = 0; k < 4000 && !(cf === c && pf === p); k++) @(negedge ref_clk);
      if (k == 4000) begin
         num_errors++;
         $display("wrong value at %0t: frequency never settled", $time);
         results();
      end else begin
         chk({cf, pf}, {c, p});
      end
   endtask : settle

   // a frequency change never jumps by more than one step
   always @(negedge ref_clk) begin
      if (nrst === 1'b1 && jump === 1'b1) begin
         num_errors++;
         $display("wrong value at %0t: frequency jumped", $time);
      end
      pcf <= cf;
      ppf <= pf;
   end

   // main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk) nrst = 1'b1;
      chk(cfg, 32'h23EF4500);
      settle(16'h2710, 16'h0D02);
      @(negedge ref_clk) pin = 1'b0;
      settle(16'h1A18, 16'h0D0C);
      // every code and every function through full frames
      for (int j = 0; j < 8; j++) begin
         d = rnd() & 32'h23EF457B;
         d[25] = d[24];
         d[6:4] = j[2:0];
         d[3] = 1'b1;
         d[1:0] = j[1:0];
         frame(8'hD2, d, 9, 0);
         chk(host.acks, 10);
         chk(sdo, 32'h0);
         chk(cfg, d);
         chk({byp, spr, oe_n}, {j[1:0] == 2'd1, j[1:0] == 2'd2, j[1:0] == 2'd3});
         t = rnd();
         @(negedge ref_clk) raw = t[14:0];
         #1 chk(cout, exp_clk(d, raw));
         settle(cpu_t[j], pci_t[j]);
      end
      // foreign address: no acknowledge, nothing changes
      frame(8'hD3, ~d, 9, 0);
      chk(host.acks, 0);
      chk(cfg, d);
      // write ending after data4 leaves pci and reference enables alone
      e = ~d & 32'h23EF457B;
      frame(8'hD2, e, 7, 0);
      chk(cfg, {d[31:16], e[15:0]});
      // torn final byte is dropped
      e = rnd() & 32'h23EF457B;
      frame(8'hD2, e, 8, 5);
      chk(cfg, {d[31:24], e[23:0]});
      results();
   end

   // watchdog for the whole run
   initial begin
      repeat (100000) @(posedge ref_clk);
      num_errors++;
      $display("wrong value at %0t: run timed out", $time);
      results();
   end
endmodule : sco_top_bench
